// ===== rtl/hmu_top.sv
`timescale 1ns/1ns
`include "hmu_defs.svh"

// How it works
// - The segment supplying instructions is never reachable as data.
// - Instruction pointer is read/write; a write redirects fetch the next cycle.
// - Instruction pointer advances by one after each fetch; branches load it.
// - Flash sits at program words 0000h-7FFFh in two 16K-word pages.
// - Utility ROM decodes at program words 8000h-8FFFh.
// - SRAM decodes at program words A000h-A3FFh.
// - Program-space placement never changes with execution segment or access mode.
// - User code starts at flash word 0000h.
// - Every data access, word or byte, completes in one clock.
// - Two data pointers and one frame pointer; source loads, destination stores.
// - A source pointer may step up or down after the read.
// - A destination pointer may step up or down before the write.
// - Frame address is 16-bit sum of base and 8-bit displacement.
// - Frame steps change only the displacement, wrapping, never touching the base.
// - Data reads reach every segment but the executing one; data writes reach only SRAM.
// - Executing from SRAM or ROM, flash fills half the data space.
// - In byte mode the page select picks the flash page; word mode shows both.
// - From flash: SRAM read/write, ROM read-only at data 8000h.
// - From ROM: SRAM read/write, flash at data 8000h, one page per page select in byte mode, both in word mode.
// - From SRAM: flash at data 0000h, ROM read-only at 8000h.
// - Byte mode addresses the word without bit 0; bit 0 picks the lane.
module hmu_top (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic [7:0]        i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [7:0]        i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic              i_fetch,
  input  wire logic              i_ip_load,
  input  wire logic [15:0]       i_ip_load_value,
  output logic [15:0]            o_fetch_addr,
  output logic [15:0]            o_instr,
  output logic                   o_instr_valid,
  input  wire logic              i_acc_valid,
  input  wire hmu_pkg::hmu_acc_s i_acc,
  output logic                   o_acc_done,
  output logic [15:0]            o_acc_rdata,
  output logic [14:0]            o_flash_addr,
  input  wire logic [15:0]       i_flash_rdata,
  output logic [11:0]            o_rom_addr,
  input  wire logic [15:0]       i_rom_rdata,
  output logic [9:0]             o_sram_addr,
  input  wire logic [15:0]       i_sram_rdata,
  output logic                   o_sram_we,
  output logic [1:0]             o_sram_be,
  output logic [15:0]            o_sram_wdata
);
  import hmu_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  logic [15:0] ip_reg;
  logic [15:0] ip_next;
  logic [15:0] dp0_reg;
  logic [15:0] dp0_next;
  logic [15:0] dp1_reg;
  logic [15:0] dp1_next;
  logic [15:0] base_reg;
  logic [15:0] base_next;
  logic [7:0]  disp_reg;
  logic [7:0]  disp_next;
  logic        page_reg;
  logic        byte_reg;
  logic        aw_held_reg;
  logic [7:0]  awaddr_reg;
  logic        w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [15:0] instr_reg;
  logic        instr_valid_reg;
  logic        acc_done_reg;
  logic [15:0] acc_rdata_reg;

  // AXI4-Lite write side: address and data are held independently, then applied together.
  wire aw_fire  = i_s_axi_awvalid && o_s_axi_awready;
  wire w_fire   = i_s_axi_wvalid && o_s_axi_wready;
  wire wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_ip    = wr_fire && (awaddr_reg == `HMU_OFS_IP);
  wire wr_dp0   = wr_fire && (awaddr_reg == `HMU_OFS_DP0);
  wire wr_dp1   = wr_fire && (awaddr_reg == `HMU_OFS_DP1);
  wire wr_base  = wr_fire && (awaddr_reg == `HMU_OFS_BASE);
  wire wr_disp  = wr_fire && (awaddr_reg == `HMU_OFS_DISP) && wstrb_reg[0];
  wire wr_ctrl  = wr_fire && (awaddr_reg == `HMU_OFS_CTRL) && wstrb_reg[0];
  wire wr_known = wr_ip || wr_dp0 || wr_dp1 || wr_base || (awaddr_reg == `HMU_OFS_DISP) ||
                  (awaddr_reg == `HMU_OFS_CTRL);

  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `HMU_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= i_s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= i_s_axi_wdata;
        wstrb_reg  <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_known ? `HMU_RESP_OKAY : `HMU_RESP_SLVERR;
      end else if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
    end
  end

  wire      in_flash = (ip_reg <= `HMU_FLASH_LAST);
  wire      in_rom   = (ip_reg >= `HMU_ROM_FIRST) && (ip_reg <= `HMU_ROM_LAST);
  wire      in_sram  = (ip_reg >= `HMU_SRAM_FIRST) && (ip_reg <= `HMU_SRAM_LAST);
  hmu_seg_e prog_seg;
  assign prog_seg = in_flash ? HMU_SEG_FLASH : in_rom ? HMU_SEG_ROM :
                    in_sram ? HMU_SEG_SRAM : HMU_SEG_NONE;
  wire [15:0] prog_rdata = (prog_seg == HMU_SEG_FLASH) ? i_flash_rdata :
                           (prog_seg == HMU_SEG_ROM) ? i_rom_rdata :
                           (prog_seg == HMU_SEG_SRAM) ? i_sram_rdata : 16'h0000;

  wire [15:0] dp0_step;
  wire [15:0] dp1_step;
  wire [7:0]  disp_step;
  hmu_ptr_step #(.W(16)) u_step_dp0 (.i_value(dp0_reg), .i_mod(i_acc.mod), .o_value(dp0_step));
  hmu_ptr_step #(.W(16)) u_step_dp1 (.i_value(dp1_reg), .i_mod(i_acc.mod), .o_value(dp1_step));
  hmu_ptr_step #(.W(8))  u_step_disp (.i_value(disp_reg), .i_mod(i_acc.mod), .o_value(disp_step));

  wire [15:0] frame_addr = base_reg + {8'h00, disp_reg};
  wire [15:0] frame_pre  = base_reg + {8'h00, disp_step};
  wire [15:0] ptr_cur    = (i_acc.ptr == HMU_PTR_DP0) ? dp0_reg :
                           (i_acc.ptr == HMU_PTR_DP1) ? dp1_reg : frame_addr;
  wire [15:0] ptr_pre    = (i_acc.ptr == HMU_PTR_DP0) ? dp0_step :
                           (i_acc.ptr == HMU_PTR_DP1) ? dp1_step : frame_pre;
  // read uses old value, write uses stepped value
  wire [15:0] eff = i_acc.write ? ptr_pre : ptr_cur;

  // byte mode word index and lane
  wire [14:0] data_off   = eff[14:0];
  wire        lane       = eff[0];
  wire [14:0] data_widx  = byte_reg ? {1'b0, data_off[14:1]} : data_off;
  wire [14:0] flash_didx = byte_reg ? {page_reg, data_off[14:1]} : data_off;

  hmu_seg_e lo_seg;
  hmu_seg_e hi_seg;
  hmu_seg_e cand_seg;
  hmu_seg_e data_seg;
  assign lo_seg   = (prog_seg == HMU_SEG_SRAM) ? HMU_SEG_FLASH : HMU_SEG_SRAM;
  assign hi_seg   = (prog_seg == HMU_SEG_ROM) ? HMU_SEG_FLASH : HMU_SEG_ROM;
  assign cand_seg = eff[15] ? hi_seg : lo_seg;
  wire data_hit = (cand_seg == HMU_SEG_FLASH) ||
                  ((cand_seg == HMU_SEG_SRAM) && (data_widx < `HMU_SRAM_WORDS)) ||
                  ((cand_seg == HMU_SEG_ROM) && (data_widx < `HMU_ROM_WORDS));
  assign data_seg = data_hit ? cand_seg : HMU_SEG_NONE;

  // Each segment has one port, owned by the fetch when it is the executing segment.
  assign o_fetch_addr = ip_reg;
  assign o_flash_addr = (prog_seg == HMU_SEG_FLASH) ? ip_reg[14:0] : flash_didx;
  assign o_rom_addr   = (prog_seg == HMU_SEG_ROM) ? ip_reg[11:0] : data_widx[11:0];
  assign o_sram_addr  = (prog_seg == HMU_SEG_SRAM) ? ip_reg[9:0] : data_widx[9:0];

  wire acc_wr = i_acc_valid && i_acc.write;
  assign o_sram_we    = acc_wr && (data_seg == HMU_SEG_SRAM);
  assign o_sram_be    = byte_reg ? (lane ? 2'b10 : 2'b01) : 2'b11;
  assign o_sram_wdata = byte_reg ? {i_acc.wdata[7:0], i_acc.wdata[7:0]} : i_acc.wdata;

  wire [15:0] data_word = (data_seg == HMU_SEG_FLASH) ? i_flash_rdata :
                          (data_seg == HMU_SEG_ROM) ? i_rom_rdata :
                          (data_seg == HMU_SEG_SRAM) ? i_sram_rdata : 16'h0000;
  wire [15:0] data_rd   = byte_reg ? {8'h00, lane ? data_word[15:8] : data_word[7:0]} : data_word;

  wire mod_en = i_acc_valid && (i_acc.mod != HMU_MOD_NONE);
  assign ip_next   = wr_ip ? merge16(ip_reg, wdata_reg, wstrb_reg) :
                     i_ip_load ? i_ip_load_value :
                     i_fetch ? ip_reg + `HMU_IP_STEP : ip_reg;
  assign dp0_next  = wr_dp0 ? merge16(dp0_reg, wdata_reg, wstrb_reg) :
                     (mod_en && i_acc.ptr == HMU_PTR_DP0) ? dp0_step : dp0_reg;
  assign dp1_next  = wr_dp1 ? merge16(dp1_reg, wdata_reg, wstrb_reg) :
                     (mod_en && i_acc.ptr == HMU_PTR_DP1) ? dp1_step : dp1_reg;
  assign base_next = wr_base ? merge16(base_reg, wdata_reg, wstrb_reg) : base_reg;
  assign disp_next = wr_disp ? wdata_reg[7:0] :
                     (mod_en && i_acc.ptr == HMU_PTR_FRAME) ? disp_step : disp_reg;

  // reset enters ROM, which hands off to flash 0000h
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ip_reg   <= `HMU_IP_RST;
      dp0_reg  <= `HMU_PTR_RST;
      dp1_reg  <= `HMU_PTR_RST;
      base_reg <= `HMU_PTR_RST;
      disp_reg <= `HMU_DISP_RST;
      page_reg <= 1'b0;
      byte_reg <= 1'b0;
    end else begin
      ip_reg   <= ip_next;
      dp0_reg  <= dp0_next;
      dp1_reg  <= dp1_next;
      base_reg <= base_next;
      disp_reg <= disp_next;
      if (wr_ctrl) begin
        page_reg <= wdata_reg[`HMU_CTRL_PAGE];
        byte_reg <= wdata_reg[`HMU_CTRL_BYTE];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      instr_reg       <= 16'h0000;
      instr_valid_reg <= 1'b0;
      acc_done_reg    <= 1'b0;
      acc_rdata_reg   <= 16'h0000;
    end else begin
      instr_valid_reg <= i_fetch;
      acc_done_reg    <= i_acc_valid;
      if (i_fetch) begin
        instr_reg <= prog_rdata;
      end
      if (i_acc_valid && !i_acc.write) begin
        acc_rdata_reg <= data_rd;
      end
    end
  end

  assign o_instr       = instr_reg;
  assign o_instr_valid = instr_valid_reg;
  assign o_acc_done    = acc_done_reg;
  assign o_acc_rdata   = acc_rdata_reg;

  // AXI4-Lite read side: one read at a time, answered the cycle after the address is taken.
  wire        ar_fire = i_s_axi_arvalid && o_s_axi_arready;
  wire [31:0] stat_word = {28'h0000000, byte_reg, page_reg, prog_seg};
  wire [31:0] ctrl_word = {30'h00000000, byte_reg, page_reg};
  wire        rd_known = (i_s_axi_araddr <= `HMU_OFS_FRAME) && (i_s_axi_araddr[1:0] == 2'b00);
  wire [31:0] rd_word  = (i_s_axi_araddr == `HMU_OFS_IP) ? {16'h0000, ip_reg} :
                         (i_s_axi_araddr == `HMU_OFS_DP0) ? {16'h0000, dp0_reg} :
                         (i_s_axi_araddr == `HMU_OFS_DP1) ? {16'h0000, dp1_reg} :
                         (i_s_axi_araddr == `HMU_OFS_BASE) ? {16'h0000, base_reg} :
                         (i_s_axi_araddr == `HMU_OFS_DISP) ? {24'h000000, disp_reg} :
                         (i_s_axi_araddr == `HMU_OFS_CTRL) ? ctrl_word :
                         (i_s_axi_araddr == `HMU_OFS_STAT) ? stat_word :
                         (i_s_axi_araddr == `HMU_OFS_FRAME) ? {16'h0000, frame_addr} : 32'h00000000;

  assign o_s_axi_arready = !rvalid_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `HMU_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_known ? `HMU_RESP_OKAY : `HMU_RESP_SLVERR;
    end else if (rvalid_reg && i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  sequence s_read_req;
    i_acc_valid && !i_acc.write;
  endsequence

  sequence s_read_done;
    o_acc_done;
  endsequence

  property p_ip_redirect;
    @(posedge i_clk_sys) disable iff (i_rst)
      (wr_ip && wstrb_reg[1:0] == 2'b11) |=> (o_fetch_addr == $past(wdata_reg[15:0]));
  endproperty
  a_ip_redirect: assert property (p_ip_redirect)
    else $error("Instruction pointer write did not redirect the fetch.");

  property p_ip_step;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_fetch && !wr_ip && !i_ip_load) |=> (ip_reg == $past(ip_reg) + `HMU_IP_STEP);
  endproperty
  a_ip_step: assert property (p_ip_step)
    else $error("Instruction pointer did not advance by one after a fetch.");

  property p_no_shared;
    @(posedge i_clk_sys) disable iff (i_rst)
      (prog_seg != HMU_SEG_NONE) |-> (data_seg != prog_seg);
  endproperty
  a_no_shared: assert property (p_no_shared)
    else $error("Executing segment is mapped as data.");

  property p_write_sram_only;
    @(posedge i_clk_sys) disable iff (i_rst)
      (acc_wr && data_seg != HMU_SEG_SRAM) |-> !o_sram_we;
  endproperty
  a_write_sram_only: assert property (p_write_sram_only)
    else $error("Data write reached a segment other than SRAM.");

  property p_one_cycle;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_read_req |=> s_read_done;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("Data read did not finish in one clock.");

  property p_sram_word_read;
    @(posedge i_clk_sys) disable iff (i_rst)
      (s_read_req ##0 (!byte_reg && data_seg == HMU_SEG_SRAM)) |=> (o_acc_rdata == $past(i_sram_rdata));
  endproperty
  a_sram_word_read: assert property (p_sram_word_read)
    else $error("Word read from SRAM returned the wrong data.");

  property p_post_inc;
    @(posedge i_clk_sys) disable iff (i_rst)
      (s_read_req ##0 (i_acc.ptr == HMU_PTR_DP0 && i_acc.mod == HMU_MOD_INC && !wr_dp0))
      |-> (eff == dp0_reg) ##1 (dp0_reg == $past(dp0_reg) + 16'h0001);
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("Source pointer was not stepped after the read.");

  property p_pre_dec;
    @(posedge i_clk_sys) disable iff (i_rst)
      (acc_wr && i_acc.ptr == HMU_PTR_DP1 && i_acc.mod == HMU_MOD_DEC && !wr_dp1)
      |-> (eff == dp1_reg - 16'h0001) ##1 (dp1_reg == $past(dp1_reg) - 16'h0001);
  endproperty
  a_pre_dec: assert property (p_pre_dec)
    else $error("Destination pointer was not stepped before the write.");

  property p_disp_wrap;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_acc_valid && i_acc.ptr == HMU_PTR_FRAME && i_acc.mod == HMU_MOD_INC && disp_reg == 8'hFF &&
       !wr_disp && !wr_base) |=> (disp_reg == 8'h00 && $stable(base_reg));
  endproperty
  a_disp_wrap: assert property (p_disp_wrap)
    else $error("Frame displacement did not wrap or the base moved.");

  property p_byte_lane;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_sram_we && byte_reg) |-> (o_sram_be == (eff[0] ? 2'b10 : 2'b01)) && (o_sram_addr == eff[10:1]);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("Byte write hit the wrong lane or word.");
endmodule

// ===== rtl/hmu_defs.svh
`ifndef HMU_DEFS_SVH
`define HMU_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define HMU_OFS_IP       8'h00
`define HMU_OFS_DP0      8'h04
`define HMU_OFS_DP1      8'h08
`define HMU_OFS_BASE     8'h0C
`define HMU_OFS_DISP     8'h10
`define HMU_OFS_CTRL     8'h14
`define HMU_OFS_STAT     8'h18
`define HMU_OFS_FRAME    8'h1C

// Control register field positions.
`define HMU_CTRL_PAGE    0
`define HMU_CTRL_BYTE    1

// Reset values.
`define HMU_IP_RST       16'h8000
`define HMU_PTR_RST      16'h0000
`define HMU_DISP_RST     8'h00

// Program space map, word addresses.
`define HMU_FLASH_LAST   16'h7FFF
`define HMU_ROM_FIRST    16'h8000
`define HMU_ROM_LAST     16'h8FFF
`define HMU_SRAM_FIRST   16'hA000
`define HMU_SRAM_LAST    16'hA3FF

// Word counts of the smaller segments inside one data half.
`define HMU_SRAM_WORDS   15'h0400
`define HMU_ROM_WORDS    15'h1000

`define HMU_IP_STEP      16'h0001
`define HMU_RESP_OKAY    2'b00
`define HMU_RESP_SLVERR  2'b10

`endif

// ===== rtl/hmu_pkg.sv
package hmu_pkg;

  typedef enum logic [1:0] {
    HMU_SEG_NONE,
    HMU_SEG_FLASH,
    HMU_SEG_ROM,
    HMU_SEG_SRAM
  } hmu_seg_e;

  typedef enum logic [1:0] {
    HMU_PTR_DP0,
    HMU_PTR_DP1,
    HMU_PTR_FRAME
  } hmu_ptr_e;

  typedef enum logic [1:0] {
    HMU_MOD_NONE,
    HMU_MOD_INC,
    HMU_MOD_DEC
  } hmu_mod_e;

  typedef struct packed {
    hmu_ptr_e    ptr;
    logic        write;
    hmu_mod_e    mod;
    logic [15:0] wdata;
  } hmu_acc_s;

endpackage

// ===== rtl/hmu_ptr_step.sv
`timescale 1ns/1ns
module hmu_ptr_step #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]      i_value,
  input  wire hmu_pkg::hmu_mod_e i_mod,
  output logic [W-1:0]           o_value
);
  import hmu_pkg::*;

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  // Steps wrap at the width of the pointer, never carrying beyond it.
  assign o_value = (i_mod == HMU_MOD_INC) ? i_value + ONE :
                   (i_mod == HMU_MOD_DEC) ? i_value - ONE : i_value;
endmodule

// ===== verification/hmu_mem_model.sv
`timescale 1ns/1ns
// Flash, utility ROM and SRAM as seen by the mapping unit, all read in the same cycle.
module hmu_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic [14:0] i_flash_addr,
  output logic [15:0]      o_flash_rdata,
  input  wire logic [11:0] i_rom_addr,
  output logic [15:0]      o_rom_rdata,
  input  wire logic [9:0]  i_sram_addr,
  output logic [15:0]      o_sram_rdata,
  input  wire logic        i_sram_we,
  input  wire logic [1:0]  i_sram_be,
  input  wire logic [15:0] i_sram_wdata
);
  logic [15:0] sram_mem [0:1023];

  // Flash and ROM contents encode their own word index so every lookup is traceable.
  assign o_flash_rdata = {1'b1, i_flash_addr};
  assign o_rom_rdata   = {4'hC, i_rom_addr};
  assign o_sram_rdata  = sram_mem[i_sram_addr];

  initial begin
    for (int i = 0; i < 1024; i++) begin
      sram_mem[i] = 16'h5000 + 16'(i);
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sram_we && i_sram_be[0]) begin
      sram_mem[i_sram_addr][7:0] <= i_sram_wdata[7:0];
    end
    if (i_sram_we && i_sram_be[1]) begin
      sram_mem[i_sram_addr][15:8] <= i_sram_wdata[15:8];
    end
  end
endmodule

// ===== verification/harvard_memory_mapping_unit_tb.sv
`timescale 1ns/1ns
`include "hmu_defs.svh"
module harvard_memory_mapping_unit_tb;
  import hmu_pkg::*;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        ipld;
  logic [15:0] ipld_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, sram_be;
  logic        fetch, instr_valid, acc_valid, acc_done, sram_we;
  logic [15:0] fetch_addr, instr, acc_rdata, flash_rdata, rom_rdata, sram_rdata, sram_wdata;
  logic [14:0] flash_addr;
  logic [11:0] rom_addr;
  logic [9:0]  sram_addr;
  hmu_acc_s    acc;
  int          err_count, samples_checked;

  hmu_top dut (
    .i_clk_sys(clk), .i_rst(rst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_fetch(fetch), .i_ip_load(ipld),
    .i_ip_load_value(ipld_val), .o_fetch_addr(fetch_addr), .o_instr(instr), .o_instr_valid(instr_valid),
    .i_acc_valid(acc_valid), .i_acc(acc), .o_acc_done(acc_done), .o_acc_rdata(acc_rdata),
    .o_flash_addr(flash_addr), .i_flash_rdata(flash_rdata), .o_rom_addr(rom_addr), .i_rom_rdata(rom_rdata),
    .o_sram_addr(sram_addr), .i_sram_rdata(sram_rdata), .o_sram_we(sram_we), .o_sram_be(sram_be),
    .o_sram_wdata(sram_wdata));

  hmu_mem_model mem (
    .i_clk_sys(clk), .i_flash_addr(flash_addr), .o_flash_rdata(flash_rdata), .i_rom_addr(rom_addr),
    .o_rom_rdata(rom_rdata), .i_sram_addr(sram_addr), .o_sram_rdata(sram_rdata), .i_sram_we(sram_we),
    .i_sram_be(sram_be), .i_sram_wdata(sram_wdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    resp = rresp;
    chk(rdata, exp);
  endtask

  task automatic fet(input logic [15:0] exp_instr, input logic [15:0] exp_ip);
    @(posedge clk);
    fetch <= 1'b1;
    @(posedge clk);
    fetch <= 1'b0;
    #1;
    chk(instr_valid, 1);
    chk(instr, exp_instr);
    chk(fetch_addr, exp_ip);
  endtask

  // A data access is expected to finish at the very next edge, reads also returning data.
  task automatic da(input hmu_ptr_e p, input logic w, input hmu_mod_e m, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc <= '{ptr: p, write: w, mod: m, wdata: d};
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    chk(acc_done, 1);
    if (!w) chk(acc_rdata, exp);
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    close_out;
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, fetch, acc_valid} = 8'hFF;
    {awvalid, wvalid, bready, arvalid, rready, fetch, acc_valid} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    acc = '0;
    ipld = 1'b0;
    ipld_val = 16'h0000;
    wstrb = 4'hF;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axr(`HMU_OFS_IP, 32'h8000);
    fet(16'hC000, 16'h8001);
    axw(`HMU_OFS_IP, 32'h7FFF);
    fet(16'hFFFF, 16'h8000);
    axw(`HMU_OFS_IP, 32'hA3FF);
    fet(16'h53FF, 16'hA400);
    axw(`HMU_OFS_IP, 32'h0000);
    fet(16'h8000, 16'h0001);
    @(posedge clk);
    ipld <= 1'b1;
    ipld_val <= 16'h0100;
    @(posedge clk);
    ipld <= 1'b0;
    fet(16'h8100, 16'h0101);
    axw(`HMU_OFS_DP0, 32'h0010);
    da(HMU_PTR_DP0, 1'b1, HMU_MOD_NONE, 16'h1234, 16'h0000);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_INC, 16'h0000, 16'h1234);
    axr(`HMU_OFS_DP0, 32'h0011);
    da(HMU_PTR_DP0, 1'b1, HMU_MOD_DEC, 16'h5555, 16'h0000);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h5555);
    axw(`HMU_OFS_DP1, 32'h8003);
    da(HMU_PTR_DP1, 1'b0, HMU_MOD_NONE, 16'h0000, 16'hC003);
    axw(`HMU_OFS_DP1, 32'h4000);
    da(HMU_PTR_DP1, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h0000);
    axw(`HMU_OFS_BASE, 32'h0005);
    axw(`HMU_OFS_DISP, 32'h00FF);
    axr(`HMU_OFS_FRAME, 32'h0104);
    da(HMU_PTR_FRAME, 1'b0, HMU_MOD_INC, 16'h0000, 16'h5104);
    axr(`HMU_OFS_FRAME, 32'h0005);
    axr(`HMU_OFS_BASE, 32'h0005);
    da(HMU_PTR_FRAME, 1'b1, HMU_MOD_DEC, 16'h7777, 16'h0000);
    axr(`HMU_OFS_DISP, 32'h00FF);
    da(HMU_PTR_FRAME, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h7777);
    wstrb <= 4'h2;
    axw(`HMU_OFS_BASE, 32'h0000AA00);
    chk(resp, `HMU_RESP_OKAY);
    axr(`HMU_OFS_BASE, 32'h0000AA05);
    axr(`HMU_OFS_FRAME, 32'h0000AB04);
    axw(`HMU_OFS_DISP, 32'h00000011);
    wstrb <= 4'hF;
    axr(`HMU_OFS_DISP, 32'h000000FF);
    axw(`HMU_OFS_IP, 32'h8000);
    axw(`HMU_OFS_DP0, 32'h8005);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h8005);
    axw(`HMU_OFS_DP0, 32'hC001);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'hC001);
    axw(`HMU_OFS_CTRL, 32'h0003);
    axw(`HMU_OFS_DP0, 32'h8003);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h00C0);
    axw(`HMU_OFS_CTRL, 32'h0002);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h0080);
    axw(`HMU_OFS_DP1, 32'h0021);
    da(HMU_PTR_DP1, 1'b1, HMU_MOD_NONE, 16'h00AB, 16'h0000);
    axw(`HMU_OFS_CTRL, 32'h0000);
    axw(`HMU_OFS_DP1, 32'h0010);
    da(HMU_PTR_DP1, 1'b0, HMU_MOD_NONE, 16'h0000, 16'hAB55);
    da(HMU_PTR_DP1, 1'b1, HMU_MOD_DEC, 16'h2468, 16'h0000);
    da(HMU_PTR_DP1, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h2468);
    axr(`HMU_OFS_DP1, 32'h0000000F);
    axw(`HMU_OFS_IP, 32'hA000);
    axw(`HMU_OFS_DP0, 32'h0007);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h8007);
    axw(`HMU_OFS_DP0, 32'h8003);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'hC003);
    axw(`HMU_OFS_DP0, 32'h0010);
    da(HMU_PTR_DP0, 1'b0, HMU_MOD_NONE, 16'h0000, 16'h8010);
    axr(8'h20, 32'h0);
    chk(resp, `HMU_RESP_SLVERR);
    axw(`HMU_OFS_STAT, 32'h0);
    chk(resp, `HMU_RESP_SLVERR);
    close_out;
  end
endmodule
